// ---- prtrng_defs.vh ----
// prtrng_defs.vh: constants for the pll jitter random source
// assumes inclusion by bare name from the design file
`ifndef PRTRNG_DEFS_VH
`define PRTRNG_DEFS_VH

// register addresses (4-bit word index)
`define PRTRNG_ADDR_DATA 4'h0
`define PRTRNG_ADDR_STATE 4'h1
`define PRTRNG_ADDR_STATUS 4'h2
`define PRTRNG_ADDR_MASK 4'h3
`define PRTRNG_ADDR_CTRL 4'h4

// state register fields
`define PRTRNG_ST_REF_UNLOCK 0
`define PRTRNG_ST_JIT_UNLOCK 1
`define PRTRNG_ST_TOTAL_FAIL 2
`define PRTRNG_ST_ONLINE_ONE 3
`define PRTRNG_ST_ONLINE_TWO 4
`define PRTRNG_ST_FULL 5

// interrupt status bits
`define PRTRNG_IRQ_ALARM 0
`define PRTRNG_IRQ_FULL 1

// pll factors and accumulation
`define PRTRNG_REF_MULT 31
`define PRTRNG_REF_DIV 12
`define PRTRNG_JIT_MULT 37
`define PRTRNG_JIT_DIV 7
`define PRTRNG_TOTAL_MULT 444
`define PRTRNG_TOTAL_DIV 217
`define PRTRNG_OSC_MHZ 50

// test figures
`define PRTRNG_TOTAL_FAIL_RUN 64
`define PRTRNG_ONLINE_WIN 1024
`define PRTRNG_ONLINE_LO 384
`define PRTRNG_ONLINE_HI 640
`define PRTRNG_RUN_MAX 34

// reset values
`define PRTRNG_MASK_RST 2'h3
`define PRTRNG_CTRL_RST 1'h1

`endif

// ---- prtrng_core.v ----
// prtrng_core.v: pll jitter random source, decimator, tests and register port
// assumes clock_in is the reference clock and jitter_clk_in the jittery clock
// Overview of operation
// R1 - sample the jittery clock on each reference clock rising edge
// R2 - one-bit decimator toggles on each sampled one within a period
// R3 - period end appends decimator bit to 256-bit buffer, clears decimator
// R4 - accumulation period spans 217 reference edges; overall multiplier 444
// R5 - reference pll configured with multiplier 31, divider 12
// R6 - jitter pll configured with multiplier 37, divider 7
// R7 - both plls fed from the on-chip oscillator near 50 MHz
// R8 - decimator bits delivered as random data with no post-processing
// R9 - total failure test and two online tests run continuously on raw bits
// R10 - lock loss and test failures form an error vector in a state register
// R11 - any failure raises the alarm, which interrupts the processor
// R12 - data and state readable only through the internal register port
// R13 - full buffer is flagged and held until read, then refills
`timescale 1ns/1ps
`include "prtrng_defs.vh"

module prtrng_core #(
    parameter DIV_COUNT = `PRTRNG_TOTAL_DIV,
    parameter BUF_BITS = 256
) (
    // clock and reset
    input wire clock_in,
    input wire rst_b_in,
    // jitter source and pll status
    input wire jitter_clk_in,
    input wire reference_pll_lock_in,
    input wire jitter_pll_lock_in,
    // pll configuration
    output reg [5:0] reference_pll_multiplier_out,
    output reg [5:0] reference_pll_divider_out,
    output reg [5:0] jitter_pll_multiplier_out,
    output reg [5:0] jitter_pll_divider_out,
    output reg osc_select_out,
    // register port
    input wire [3:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [31:0] rdata_out,
    // interrupt
    output reg irq_out
);

    ////////////////////////////////////////////////////////////////////
    // sampling and decimation

    localparam WORDS = BUF_BITS / 32;
    reg sample_q;
    reg decim_q;
    reg [7:0] period_q;
    reg [8:0] fill_q;
    reg [BUF_BITS-1:0] buf_q;
    reg full_q;
    reg [2:0] rd_idx_q;
    reg enable_q;
    wire period_end = (period_q == DIV_COUNT - 1);
    wire bit_now = decim_q ^ sample_q;
    wire new_bit = period_end && enable_q;

    always @(posedge clock_in) begin
        // timing note: jitter_clk_in is asynchronous by design; metastability is the source
        sample_q <= jitter_clk_in; // see R1
    end

    // period counter; eight bits limit DIV_COUNT to 256
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            period_q <= 8'h00;
        end else if (period_end) begin
            period_q <= 8'h00; // see R4
        end else begin
            period_q <= period_q + 8'h01;
        end
    end

    // the last sample of a period lands in bit_now, not in the counter
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            decim_q <= 1'b0;
        end else if (period_end) begin
            decim_q <= 1'b0; // see R3
        end else if (sample_q) begin
            decim_q <= ~decim_q; // see R2
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output buffer, raw bits go straight in, no post-processing

    wire rd_data = rd_in && (addr_in == `PRTRNG_ADDR_DATA);
    wire last_word = (rd_idx_q == WORDS - 1);

    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            buf_q <= {BUF_BITS{1'b0}};
            fill_q <= 9'h000;
            full_q <= 1'b0;
            rd_idx_q <= 3'h0;
        end else if (full_q) begin
            // held until every word is read, then refill
            if (rd_data) begin
                rd_idx_q <= rd_idx_q + 3'h1;
                if (last_word) begin
                    full_q <= 1'b0; // see R13
                    fill_q <= 9'h000;
                    rd_idx_q <= 3'h0;
                end
            end
        end else if (new_bit) begin
            buf_q <= {buf_q[BUF_BITS-2:0], bit_now}; // see R3, R8
            if (fill_q == BUF_BITS - 1)
                full_q <= 1'b1; // see R13
            fill_q <= fill_q + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // health tests on the raw stream

    reg [6:0] same_run_q;
    reg prev_bit_q;
    reg total_fail_q;
    reg [10:0] win_cnt_q;
    reg [10:0] ones_q;
    reg online_one_fail_q;
    reg [5:0] run_q;
    reg online_two_fail_q;

    // previous raw bit, shared by both run tests
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            prev_bit_q <= 1'b0;
        end else if (new_bit) begin
            prev_bit_q <= bit_now;
        end
    end

    // total_failure_test: a stuck source repeats one value, see R9
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            same_run_q <= 7'h00;
            total_fail_q <= 1'b0;
        end else if (new_bit) begin
            if (bit_now == prev_bit_q) begin
                if (same_run_q != 7'h7f)
                    same_run_q <= same_run_q + 7'h01;
                if (same_run_q >= `PRTRNG_TOTAL_FAIL_RUN - 1)
                    total_fail_q <= 1'b1;
            end else begin
                same_run_q <= 7'h00;
            end
        end
    end

    // online_test_one: ones count per window, see R9
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            win_cnt_q <= 11'h000;
            ones_q <= 11'h000;
            online_one_fail_q <= 1'b0;
        end else if (new_bit) begin
            if (win_cnt_q == `PRTRNG_ONLINE_WIN - 1) begin
                win_cnt_q <= 11'h000;
                ones_q <= 11'h000;
                if (ones_q + bit_now < `PRTRNG_ONLINE_LO ||
                    ones_q + bit_now > `PRTRNG_ONLINE_HI)
                    online_one_fail_q <= 1'b1;
            end else begin
                win_cnt_q <= win_cnt_q + 11'h001;
                ones_q <= ones_q + {10'h000, bit_now};
            end
        end
    end

    // online_test_two: long run of equal bits, see R9
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            run_q <= 6'h00;
            online_two_fail_q <= 1'b0;
        end else if (new_bit) begin
            if (bit_now == prev_bit_q) begin
                if (run_q != 6'h3f)
                    run_q <= run_q + 6'h01;
                if (run_q >= `PRTRNG_RUN_MAX - 1)
                    online_two_fail_q <= 1'b1;
            end else begin
                run_q <= 6'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // error vector, interrupts and registers

    wire [5:0] state_vec = {full_q, online_two_fail_q, online_one_fail_q,
                            total_fail_q, ~jitter_pll_lock_in, ~reference_pll_lock_in}; // see R10
    wire alarm = |state_vec[4:0]; // see R11
    reg alarm_q;
    reg full_seen_q;
    reg [1:0] status_q;
    reg [1:0] mask_q;
    wire [1:0] events = {full_q & ~full_seen_q, alarm & ~alarm_q};
    wire wr_status = wr_in && (addr_in == `PRTRNG_ADDR_STATUS);
    wire wr_mask = wr_in && (addr_in == `PRTRNG_ADDR_MASK);
    wire wr_ctrl = wr_in && (addr_in == `PRTRNG_ADDR_CTRL);

    // write-one-to-clear bits, zero when no status write
    function [1:0] clr_bits;
        input wr;
        input [1:0] d;
        begin
            clr_bits = wr ? d : 2'h0;
        end
    endfunction

    // set beats clear, so an event in the clearing cycle is never lost
    wire [1:0] status_d = (status_q & ~clr_bits(wr_status, wdata_in[1:0])) | events;

    // pll factors are driven on every cycle out of reset, zero in reset; the plls need them before lock
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            reference_pll_multiplier_out <= 6'h00;
            reference_pll_divider_out <= 6'h00;
            jitter_pll_multiplier_out <= 6'h00;
            jitter_pll_divider_out <= 6'h00;
            osc_select_out <= 1'b0;
        end else begin
            reference_pll_multiplier_out <= `PRTRNG_REF_MULT; // see R5
            reference_pll_divider_out <= `PRTRNG_REF_DIV; // see R5
            jitter_pll_multiplier_out <= `PRTRNG_JIT_MULT; // see R6
            jitter_pll_divider_out <= `PRTRNG_JIT_DIV; // see R6
            osc_select_out <= 1'b1; // see R7
        end
    end

    // status, mask, control and the interrupt line
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            alarm_q <= 1'b0;
            full_seen_q <= 1'b0;
            status_q <= 2'h0;
            mask_q <= `PRTRNG_MASK_RST;
            enable_q <= `PRTRNG_CTRL_RST;
            irq_out <= 1'b0;
        end else begin
            alarm_q <= alarm;
            full_seen_q <= full_q;
            status_q <= status_d;
            if (wr_mask)
                mask_q <= wdata_in[1:0];
            if (wr_ctrl)
                enable_q <= wdata_in[0];
            // same-cycle events included so the line does not lag the status bit
            irq_out <= |(status_d & mask_q); // see R11
        end
    end

    // read answer stands one cycle only, zero otherwise
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            rdata_out <= 32'h0000_0000;
        end else begin
            rdata_out <= 32'h0000_0000;
            if (rd_in) begin
                // internal port only, see R12
                case (addr_in)
                    `PRTRNG_ADDR_DATA: rdata_out <= full_q ? buf_q[rd_idx_q*32 +: 32] : 32'h0;
                    `PRTRNG_ADDR_STATE: rdata_out <= {26'h0, state_vec}; // see R10
                    `PRTRNG_ADDR_STATUS: rdata_out <= {30'h0, status_q};
                    `PRTRNG_ADDR_MASK: rdata_out <= {30'h0, mask_q};
                    `PRTRNG_ADDR_CTRL: rdata_out <= {31'h0, enable_q};
                    default: rdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

// ---- prtrng_props.sv ----
// prtrng_props.sv: port checks for prtrng_core
// assumes a bind onto prtrng_core, one clock
`timescale 1ns/1ps
module prtrng_props (
    // clock, reset, source
    input wire clock_in,
    input wire rst_b_in,
    input wire jitter_clk_in,
    input wire reference_pll_lock_in,
    // pll configuration
    input wire [5:0] reference_pll_multiplier_out,
    input wire [5:0] reference_pll_divider_out,
    input wire [5:0] jitter_pll_multiplier_out,
    input wire [5:0] jitter_pll_divider_out,
    input wire osc_select_out,
    // register port
    input wire [3:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [31:0] rdata_out,
    input wire irq_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    // run of sampled ones; wide so it covers a test on decimated bits too
    reg [10:0] ones_q;
    always @(posedge clock_in) begin
        ones_q <= !jitter_clk_in ? 11'h0 : ones_q + {10'h0, ones_q != 11'h7ff};
    end
    sequence state_rd;
        rd_in && addr_in == 4'h1;
    endsequence
    ref_cfg_a: assert property (rst_b_in [*3] |-> reference_pll_multiplier_out == 6'h1f
        && reference_pll_divider_out == 6'h0c) else $error("reference pll factors wrong");
    jit_cfg_a: assert property (rst_b_in [*3] |-> jitter_pll_multiplier_out == 6'h25
        && jitter_pll_divider_out == 6'h07) else $error("jitter pll factors wrong");
    osc_sel_a: assert property (rst_b_in [*3] |-> osc_select_out)
        else $error("internal oscillator not selected");
    rd_gap_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data outside read answer");
    unmapped_rd_a: assert property (rd_in && addr_in > 4'h4 |=> rdata_out == 32'h0)
        else $error("unmapped read not zero");
    unlock_state_a: assert property (!reference_pll_lock_in [*3] ##0 state_rd |=> rdata_out[0])
        else $error("lock loss missing in state");
    stuck_state_a: assert property (ones_q > 11'h400 ##0 state_rd |=> rdata_out[2])
        else $error("stuck source not flagged");
    mask_off_a: assert property (wr_in && addr_in == 4'h3 && wdata_in[1:0] == 2'h0 ##1 !wr_in
        |=> !irq_out) else $error("masked interrupt still high");
endmodule
bind prtrng_core prtrng_props u_props (.*);

// ---- prtrng_cpu.sv ----
// prtrng_cpu.sv: processor model on the register port
// assumes tasks are entered just after a rising edge
`timescale 1ns/1ps
module prtrng_cpu (
    // clock
    input wire clock_in,
    // register port toward the block
    output reg [3:0] addr_out,
    output reg [31:0] wdata_out,
    output reg wr_out,
    output reg rd_out
);
    initial begin
        addr_out = 4'h0;
        wdata_out = 32'h0;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // one strobe cycle; data and state only reach us over this port
    task acc(input reg wr, input reg [3:0] a, input reg [31:0] d);
        begin
            addr_out <= a;
            wdata_out <= d;
            wr_out <= wr;
            rd_out <= !wr;
            @(posedge clock_in);
            wr_out <= 1'b0;
            rd_out <= 1'b0;
        end
    endtask
endmodule

// ---- tb.sv ----
// tb.sv: self-checking bench for prtrng_core
// assumes prtrng_cpu drives the register port
`timescale 1ns/1ps
module tb;
    reg clock_in, rst_b_in, jitter_clk_in, ref_lock, jit_lock, rnd_on, rd_seen;
    reg [31:0] lfsr_q;
    integer n_fail, samples_checked, i;
    reg [63:0] exp_q[$];
    wire [3:0] addr;
    wire [31:0] wdata, rdata;
    wire wr, rd, irq;
    prtrng_cpu cpu (.clock_in(clock_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
        .rd_out(rd));
    // short period keeps the run small; odd count makes a steady one give bit 1
    prtrng_core #(.DIV_COUNT(5)) DUT (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .jitter_clk_in(jitter_clk_in), .reference_pll_lock_in(ref_lock),
        .jitter_pll_lock_in(jit_lock), .reference_pll_multiplier_out(),
        .reference_pll_divider_out(), .jitter_pll_multiplier_out(), .jitter_pll_divider_out(),
        .osc_select_out(), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .irq_out(irq));
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        lfsr_q <= lfsr(lfsr_q);
        jitter_clk_in <= rnd_on ? lfsr_q[0] : 1'b1;
    end
    task check(input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // compare and pop in one process so the oldest note is used exactly once
    always @(posedge clock_in) begin
        if (rd_seen && exp_q.size() > 0) begin
            check(rdata & exp_q[0][63:32], exp_q[0][31:0]);
            exp_q.pop_front();
        end
        rd_seen <= rd;
    end
    task wr_reg(input [3:0] a, input [31:0] d);
        begin
            cpu.acc(1'b1, a, d);
            @(posedge clock_in);
        end
    endtask
    task rd_reg(input [3:0] a, input [31:0] m, input [31:0] e);
        begin
            exp_q.push_back({m, e});
            cpu.acc(1'b0, a, 32'h0);
            @(posedge clock_in);
        end
    endtask
    task wait_irq(input v);
        begin
            for (i = 0; i < 2000 && irq !== v; i = i + 1) @(posedge clock_in);
            check({31'h0, irq}, {31'h0, v});
        end
    endtask
    task end_of_test;
        begin
            $display("compares %0d mismatches %0d", samples_checked, n_fail);
            if (n_fail == 0 && samples_checked > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        #160000;
        n_fail = n_fail + 1;
        end_of_test;
    end
    initial begin
        {rst_b_in, jitter_clk_in, rd_seen} = 3'h0;
        {ref_lock, jit_lock, rnd_on} = 3'h7;
        lfsr_q = 32'hea69;
        {n_fail, samples_checked} = 64'h0;
        repeat (6) @(posedge clock_in);
        rst_b_in <= 1'b1;
        @(posedge clock_in);
        rd_reg(4'h3, 32'hffffffff, 32'h3);
        rd_reg(4'h4, 32'hffffffff, 32'h1);
        rd_reg(4'h7, 32'hffffffff, 32'h0);
        rd_reg(4'h0, 32'hffffffff, 32'h0);
        wait_irq(1'b1);
        rd_reg(4'h1, 32'hffffffff, 32'h20);
        wr_reg(4'h2, 32'h3);
        rd_reg(4'h2, 32'h3, 32'h0);
        for (int k = 0; k < 8; k++) rd_reg(4'h0, 32'h0, 32'h0);
        rd_reg(4'h1, 32'h20, 32'h0);
        ref_lock <= 1'b0;
        repeat (4) @(posedge clock_in);
        rd_reg(4'h1, 32'h1, 32'h1);
        wait_irq(1'b1);
        ref_lock <= 1'b1;
        rst_b_in <= 1'b0;
        rnd_on <= 1'b0;
        repeat (6) @(posedge clock_in);
        rst_b_in <= 1'b1;
        @(posedge clock_in);
        wait_irq(1'b1);
        rd_reg(4'h1, 32'h10, 32'h10);
        wr_reg(4'h3, 32'h0);
        wr_reg(4'h2, 32'h3);
        repeat (1400) @(posedge clock_in);
        wait_irq(1'b0);
        rd_reg(4'h2, 32'h2, 32'h2);
        wr_reg(4'h3, 32'h2);
        wait_irq(1'b1);
        rd_reg(4'h1, 32'h4, 32'h4);
        for (int k = 0; k < 8; k++) rd_reg(4'h0, 32'hffffffff, 32'hffffffff);
        repeat (2) @(posedge clock_in);
        end_of_test;
    end
endmodule
